//--- hdl/fim_top.sv
// interrupt request, mask and cause logic for the tx and rx fifo groups
//
// Overview of operation
// [RQ1] cause value has four group bits; several may be set together
// [RQ2] tx level request high while tx fill count is below threshold
// [RQ3] tx has-space request high while tx fifo has a free entry
// [RQ4] tx drained request high while tx fifo is empty
// [RQ5] write to full tx fifo sets tx overflow request
// [RQ6] transmitter read of empty tx fifo sets tx underflow request
// [RQ7] card-mode nack on transmitted character sets tx nack request
// [RQ8] all queued tx data shifted out sets tx done request
// [RQ9] driven tx level differing from sampled rx sets mismatch request
// [RQ10] each group has a writable mask that reads back unchanged
// [RQ11] masked view is request AND mask per bit, read only
// [RQ12] clearing tx level, space or drained has no effect while condition holds
// [RQ13] stretching target: tx underflow clear ignored until data is written
// [RQ14] writing ones to the set register forces tx request bits
// [RQ15] tx threshold accepts 0 up to tx depth minus one
// [RQ16] rx level request high while rx fill count exceeds threshold
// [RQ17] rx not-empty while any entry; rx full while fifo full
// [RQ18] write into full rx fifo sets rx overflow request
// [RQ19] read of empty rx fifo sets rx underflow request
// [RQ20] invalid stop bit sets rx framing request
// [RQ21] parity mismatch sets rx parity request
// [RQ22] clearing rx level, entry or full has no effect while condition holds
// [RQ23] irq is OR of all masked bits; cause bit ORs its group
//
// The placing of the registers and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
module fim_top
   import fim_pkg::*;
#(
   parameter int TX_DEPTH = 8,
   parameter int RX_DEPTH = 8,
   parameter int CNT_W = 4
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [CNT_W-1:0] tx_count,
   input wire logic [CNT_W-1:0] rx_count,
   input wire fim_evt_s evt,
   input wire logic [GRP_W-1:0] ctl_req,
   input wire logic [GRP_W-1:0] tgt_req,
   output logic [CNT_W-1:0] tx_level_out,
   output logic [CNT_W-1:0] rx_level_out,
   output logic irq
);
   // refuse depths that the counters cannot hold, at elaboration
   if (TX_DEPTH < 2 || RX_DEPTH < 2 || (1 << CNT_W) <= TX_DEPTH
       || (1 << CNT_W) <= RX_DEPTH || CNT_W > 16) begin : g_bad_params
      $error("fim_top: depth and count width do not fit");
   end

   typedef struct packed {
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [TX_W-1:0] tx_req;
      logic [TX_W-1:0] tx_mask;
      logic [RX_W-1:0] rx_req;
      logic [RX_W-1:0] rx_mask;
      logic [GRP_W-1:0] ctl_mask;
      logic [GRP_W-1:0] tgt_mask;
      logic [CNT_W-1:0] tx_level;
      logic [CNT_W-1:0] rx_level;
      logic unf_hold;
      logic [31:0] rdata;
      logic irq;
   } fim_state_s;

   fim_state_s st_ff;
   fim_state_s nxt_st;

   localparam logic [CNT_W-1:0] TX_MAX_LVL = CNT_W'(TX_DEPTH - 1);
   localparam logic [CNT_W-1:0] RX_MAX_LVL = CNT_W'(RX_DEPTH - 1);
   localparam logic [CNT_W-1:0] TX_FULL_CNT = CNT_W'(TX_DEPTH);
   localparam logic [CNT_W-1:0] RX_FULL_CNT = CNT_W'(RX_DEPTH);
   localparam logic [CNT_W-1:0] CNT_ZERO = '0;

   logic [TX_W-1:0] tx_cond;
   logic [TX_W-1:0] tx_evt;
   logic [RX_W-1:0] rx_cond;
   logic [RX_W-1:0] rx_evt;
   logic [TX_W-1:0] tx_masked;
   logic [RX_W-1:0] rx_masked;
   logic [GRP_W-1:0] ctl_masked;
   logic [GRP_W-1:0] tgt_masked;
   logic [3:0] cause;
   logic addr_ok;

   ////////////////////////////////////////////////////////////////////////////
   // live fifo conditions; these re-assert the request every cycle they hold
   always_comb begin
      tx_cond = '0;
      tx_cond[TXB_BELOW] = tx_count < st_ff.tx_level; // RQ2
      tx_cond[TXB_SPACE] = tx_count < TX_FULL_CNT; // RQ3
      tx_cond[TXB_DRAINED] = tx_count == CNT_ZERO; // RQ4
      // underflow held while stretching target sits on an empty fifo
      tx_cond[TXB_UNF] = st_ff.unf_hold; // RQ13
      tx_evt = '0;
      tx_evt[TXB_OVF] = evt.tx_write_full; // RQ5
      tx_evt[TXB_UNF] = evt.tx_read_empty; // RQ6
      tx_evt[TXB_NACK] = evt.tx_nack; // RQ7
      tx_evt[TXB_DONE] = evt.tx_done; // RQ8
      tx_evt[TXB_MISMATCH] = evt.tx_mismatch; // RQ9
      rx_cond = '0;
      rx_cond[RXB_ABOVE] = rx_count > st_ff.rx_level; // RQ16
      rx_cond[RXB_ENTRY] = rx_count != CNT_ZERO; // RQ17
      rx_cond[RXB_FILLED] = rx_count >= RX_FULL_CNT; // RQ17
      rx_evt = '0;
      rx_evt[RXB_OVF] = evt.rx_write_full; // RQ18
      rx_evt[RXB_UNF] = evt.rx_read_empty; // RQ19
      rx_evt[RXB_STOP] = evt.rx_stop_fault; // RQ20
      rx_evt[RXB_PARITY] = evt.rx_parity_fault; // RQ21
   end

   // masked views and cause summary
   assign tx_masked = st_ff.tx_req & st_ff.tx_mask; // RQ11
   assign rx_masked = st_ff.rx_req & st_ff.rx_mask; // RQ11
   assign ctl_masked = ctl_req & st_ff.ctl_mask; // RQ11
   assign tgt_masked = tgt_req & st_ff.tgt_mask; // RQ11
   always_comb begin
      cause = '0;
      cause[CB_CTL] = |ctl_masked; // RQ23
      cause[CB_TGT] = |tgt_masked; // RQ23
      cause[CB_TX] = |tx_masked; // RQ23
      cause[CB_RX] = |rx_masked; // RQ1
   end

   // only whole-word accesses inside the map are served; others read zero,
   // writes dropped, so an alias above the low byte cannot hit a register
   assign addr_ok = (hsize == HSIZE_WORD) && (haddr[31:8] == 24'h000000);

   ////////////////////////////////////////////////////////////////////////////
   // next state: bus decode, clear/set, sticky events
   always_comb begin
      logic [TX_W-1:0] tx_clr;
      logic [TX_W-1:0] tx_set;
      logic [RX_W-1:0] rx_clr;
      logic [RX_W-1:0] rx_set;
      logic [CNT_W-1:0] wlvl;
      tx_clr = '0;
      tx_set = '0;
      rx_clr = '0;
      rx_set = '0;
      wlvl = hwdata[CNT_W-1:0];
      nxt_st = st_ff;
      nxt_st.wr_pend = 1'b0;
      // data phase of a posted write
      if (st_ff.wr_pend) begin
         unique case (st_ff.wr_addr)
            OFS_TX_REQ: tx_clr = hwdata[TX_W-1:0];
            OFS_TX_SET: tx_set = hwdata[TX_W-1:0]; // RQ14
            OFS_TX_MASK: nxt_st.tx_mask = hwdata[TX_W-1:0]; // RQ10
            OFS_TX_LEVEL: begin
               // out-of-range level saturates at depth minus one
               nxt_st.tx_level = (wlvl > TX_MAX_LVL) ? TX_MAX_LVL : wlvl; // RQ15
            end
            OFS_RX_REQ: rx_clr = hwdata[RX_W-1:0];
            OFS_RX_SET: rx_set = hwdata[RX_W-1:0];
            OFS_RX_MASK: nxt_st.rx_mask = hwdata[RX_W-1:0]; // RQ10
            OFS_RX_LEVEL: begin
               nxt_st.rx_level = (wlvl > RX_MAX_LVL) ? RX_MAX_LVL : wlvl;
            end
            OFS_CTL_MASK: nxt_st.ctl_mask = hwdata[GRP_W-1:0]; // RQ10
            OFS_TGT_MASK: nxt_st.tgt_mask = hwdata[GRP_W-1:0]; // RQ10
            default: ;
         endcase
      end
      // set wins over clear; live conditions beat any clear
      nxt_st.tx_req = (st_ff.tx_req & ~tx_clr) | tx_set | tx_evt | tx_cond; // RQ12
      nxt_st.rx_req = (rx_cond | rx_evt | rx_set) | (st_ff.rx_req & ~rx_clr); // RQ22
      // stretch hold starts on an underflow, ends when data is written
      if (evt.tx_written || !evt.tgt_stretch) begin
         nxt_st.unf_hold = 1'b0; // RQ13
      end else if (evt.tx_read_empty && tx_count == CNT_ZERO) begin
         nxt_st.unf_hold = 1'b1; // RQ13
      end
      // address phase
      if (hsel && hready && htrans == HTRANS_NONSEQ) begin
         nxt_st.wr_pend = hwrite && addr_ok;
         nxt_st.wr_addr = haddr[7:0];
         nxt_st.rdata = '0;
         if (!hwrite && addr_ok && haddr[31:8] == 24'h000000) begin
            unique case (haddr[7:0])
               OFS_CAUSE: nxt_st.rdata[3:0] = cause; // RQ1
               OFS_TX_REQ: nxt_st.rdata[TX_W-1:0] = st_ff.tx_req;
               OFS_TX_MASK: nxt_st.rdata[TX_W-1:0] = st_ff.tx_mask; // RQ10
               OFS_TX_MASKED: nxt_st.rdata[TX_W-1:0] = tx_masked; // RQ11
               OFS_TX_LEVEL: nxt_st.rdata[CNT_W-1:0] = st_ff.tx_level;
               OFS_RX_REQ: nxt_st.rdata[RX_W-1:0] = st_ff.rx_req;
               OFS_RX_MASK: nxt_st.rdata[RX_W-1:0] = st_ff.rx_mask; // RQ10
               OFS_RX_MASKED: nxt_st.rdata[RX_W-1:0] = rx_masked; // RQ11
               OFS_RX_LEVEL: nxt_st.rdata[CNT_W-1:0] = st_ff.rx_level;
               OFS_CTL_MASK: nxt_st.rdata[GRP_W-1:0] = st_ff.ctl_mask;
               OFS_TGT_MASK: nxt_st.rdata[GRP_W-1:0] = st_ff.tgt_mask;
               default: ;
            endcase
         end
      end
      // one cycle late against the requests; keeps irq straight from a flop
      nxt_st.irq = |cause; // RQ23
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // outputs straight from flops; slave never waits and always answers okay
   assign hrdata = st_ff.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign tx_level_out = st_ff.tx_level;
   assign rx_level_out = st_ff.rx_level;
   assign irq = st_ff.irq;
endmodule : fim_top

//--- hdl/fim_pkg.sv
// package for the fifo interrupt request and mask block
package fim_pkg;
   // register byte offsets (one aligned word each)
   localparam logic [7:0] OFS_CAUSE = 8'h00;
   localparam logic [7:0] OFS_TX_REQ = 8'h10;
   localparam logic [7:0] OFS_TX_SET = 8'h14;
   localparam logic [7:0] OFS_TX_MASK = 8'h18;
   localparam logic [7:0] OFS_TX_MASKED = 8'h1C;
   localparam logic [7:0] OFS_TX_LEVEL = 8'h20;
   localparam logic [7:0] OFS_RX_REQ = 8'h30;
   localparam logic [7:0] OFS_RX_SET = 8'h34;
   localparam logic [7:0] OFS_RX_MASK = 8'h38;
   localparam logic [7:0] OFS_RX_MASKED = 8'h3C;
   localparam logic [7:0] OFS_RX_LEVEL = 8'h40;
   localparam logic [7:0] OFS_CTL_MASK = 8'h50;
   localparam logic [7:0] OFS_TGT_MASK = 8'h54;
   // group widths
   localparam int TX_W = 8;
   localparam int RX_W = 7;
   localparam int GRP_W = 16;
   // tx request bit positions
   localparam int TXB_BELOW = 0;
   localparam int TXB_SPACE = 1;
   localparam int TXB_DRAINED = 2;
   localparam int TXB_OVF = 3;
   localparam int TXB_UNF = 4;
   localparam int TXB_NACK = 5;
   localparam int TXB_DONE = 6;
   localparam int TXB_MISMATCH = 7;
   // rx request bit positions
   localparam int RXB_ABOVE = 0;
   localparam int RXB_ENTRY = 1;
   localparam int RXB_FILLED = 2;
   localparam int RXB_OVF = 3;
   localparam int RXB_UNF = 4;
   localparam int RXB_STOP = 5;
   localparam int RXB_PARITY = 6;
   // cause bit positions
   localparam int CB_CTL = 0;
   localparam int CB_TGT = 1;
   localparam int CB_TX = 2;
   localparam int CB_RX = 3;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   // fifo-side events and the stretch and write flags from the serial unit
   typedef struct packed {
      logic tx_write_full;
      logic tx_read_empty;
      logic tx_nack;
      logic tx_done;
      logic tx_mismatch;
      logic rx_write_full;
      logic rx_read_empty;
      logic rx_stop_fault;
      logic rx_parity_fault;
      logic tgt_stretch;
      logic tx_written;
   } fim_evt_s;
endpackage : fim_pkg

//--- tb/fim_monitor.sv
// port checker for the fifo interrupt block
`timescale 1ns/10ps
module fim_monitor
   import fim_pkg::*;
#(parameter int TX_DEPTH = 8, parameter int RX_DEPTH = 8, parameter int CNT_W = 4) (
   input wire logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq,
   input wire logic [31:0] haddr, hwdata, hrdata,
   input wire logic [1:0] htrans,
   input wire logic [2:0] hsize,
   input wire logic [CNT_W-1:0] tx_count, rx_count, tx_level_out, rx_level_out
);
   logic rd_ff, wr_ff, bad_ff;
   logic [7:0] ofs_ff, msk_ff;
   logic [1:0] up_ff;
   wire acc = hsel && hready && htrans == HTRANS_NONSEQ && hsize == HSIZE_WORD;
   ////////////////////////////////
   // data phase tracking; up_ff keeps two-deep history checks clear of reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {rd_ff, wr_ff, bad_ff, ofs_ff, msk_ff, up_ff} <= '0;
      end else begin
         rd_ff <= acc && !hwrite;
         wr_ff <= acc && hwrite;
         bad_ff <= haddr[31:8] != 24'h0;
         ofs_ff <= haddr[7:0];
         if (up_ff != 2'h3) up_ff <= up_ff + 2'h1;
         if (wr_ff && !bad_ff && ofs_ff == OFS_TX_MASK) msk_ff <= hwdata[7:0];
      end
   end
   ////////////////////////////////
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not okay");
   a_level_range: assert property (tx_level_out < TX_DEPTH && rx_level_out < RX_DEPTH)
      else $error("threshold too big");
   a_level_write: assert property (wr_ff && !bad_ff && ofs_ff == OFS_TX_LEVEL
      && hwdata < TX_DEPTH |=> tx_level_out == $past(hwdata[CNT_W-1:0])) else $error("level lost");
   a_cause_irq: assert property (rd_ff && !bad_ff && ofs_ff == OFS_CAUSE
      |-> hrdata[31:4] == 28'h0 && (|hrdata[3:0]) == irq) else $error("cause irq differ");
   a_unmapped_zero: assert property (rd_ff && bad_ff |-> hrdata == 32'h0) else $error("unmapped");
   a_mask_readback: assert property (rd_ff && !bad_ff && ofs_ff == OFS_TX_MASK
      |-> hrdata == {24'h0, $past(msk_ff)}) else $error("mask readback");
   a_tx_live: assert property (rd_ff && !bad_ff && ofs_ff == OFS_TX_REQ && up_ff == 2'h3
      |-> ($past(tx_count, 2) != 0 || hrdata[TXB_DRAINED])
      && ($past(tx_count, 2) >= TX_DEPTH || hrdata[TXB_SPACE])
      && ($past(tx_count, 2) >= $past(tx_level_out, 2) || hrdata[TXB_BELOW])) else $error("tx live");
   a_rx_live: assert property (rd_ff && !bad_ff && ofs_ff == OFS_RX_REQ && up_ff == 2'h3
      |-> ($past(rx_count, 2) == 0 || hrdata[RXB_ENTRY])
      && ($past(rx_count, 2) != RX_DEPTH || hrdata[RXB_FILLED])
      && ($past(rx_count, 2) <= $past(rx_level_out, 2) || hrdata[RXB_ABOVE])) else $error("rx live");
   c_cause_irq: cover property (rd_ff && ofs_ff == OFS_CAUSE && irq);
   c_tx_full: cover property (tx_count == TX_DEPTH);
   c_rx_full: cover property (rx_count == RX_DEPTH);
endmodule : fim_monitor
bind fim_top fim_monitor #(.TX_DEPTH(TX_DEPTH), .RX_DEPTH(RX_DEPTH), .CNT_W(CNT_W)) u_fim_monitor (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .hwrite(hwrite), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .haddr(haddr), .hwdata(hwdata),
   .hrdata(hrdata), .htrans(htrans), .hsize(hsize), .tx_count(tx_count), .rx_count(rx_count),
   .tx_level_out(tx_level_out), .rx_level_out(rx_level_out));

//--- tb/fim_fifo_model.sv
// serial unit fifo model: fill count and fault pulses for one direction
`timescale 1ns/10ps
module fim_fifo_model #(parameter int DEPTH = 8) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic push,
   input wire logic pop,
   output logic [3:0] count,
   output logic wr_full,
   output logic rd_empty
);
   ////////////////////////////////
   // a push when full or a pop when empty is lost but flagged for one cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {count, wr_full, rd_empty} <= '0;
      end else begin
         wr_full <= push && count == 4'(DEPTH);
         rd_empty <= pop && count == 4'h0;
         if (push && count != 4'(DEPTH)) count <= count + 4'h1;
         else if (pop && count != 4'h0) count <= count - 4'h1;
      end
   end
endmodule : fim_fifo_model

//--- tb/fim_top_tb.sv
// self-checking bench for the fifo interrupt block
`timescale 1ns/10ps
module fim_top_tb;
   import fim_pkg::*;
   localparam int DEPTH = 8;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, q, s, m, c, x;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 0;
   logic [3:0] fop = 0, r, tx_count, rx_count, tx_lvl, rx_lvl;
   logic [15:0] ctl_req = 0, tgt_req = 0;
   logic hreadyout, hresp, irq, twf, tre, rwf, rre;
   fim_evt_s ev = '0, evt;
   int failures = 0, samples_checked = 0, tn = 0;
   int ek[5] = '{8, 7, 6, 3, 2}; // packed positions of nack, done, mismatch, stop, parity
   initial forever #10 hclk = ~hclk;
   // fifo model pulses replace the bench's own values in the four fifo fault fields; the other fields come from ev
   always_comb begin
      evt = ev;
      evt.tx_write_full = twf;
      evt.tx_read_empty = tre;
      evt.rx_write_full = rwf;
      evt.rx_read_empty = rre;
   end
   fim_top #(.TX_DEPTH(DEPTH), .RX_DEPTH(DEPTH)) u_fim_top (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .tx_count(tx_count), .rx_count(rx_count), .evt(evt), .ctl_req(ctl_req),
      .tgt_req(tgt_req), .tx_level_out(tx_lvl), .rx_level_out(rx_lvl), .irq(irq));
   fim_fifo_model #(.DEPTH(DEPTH)) u_fim_fifo_model (.hclk(hclk), .hresetn(hresetn),
      .push(fop[0]), .pop(fop[1]), .count(tx_count), .wr_full(twf), .rd_empty(tre));
   fim_fifo_model #(.DEPTH(DEPTH)) u_fim_fifo_model_rx (.hclk(hclk), .hresetn(hresetn),
      .push(fop[2]), .pop(fop[3]), .count(rx_count), .wr_full(rwf), .rd_empty(rre));
   ////////////////////////////////
   // one single transfer; entered and left at a rising edge
   task automatic bus(input logic w, input logic [31:0] a, d);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      haddr <= a;
      hsize <= HSIZE_WORD;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask : bus
   task automatic chk(input logic [31:0] g, e);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic rc(input logic [31:0] a, e);
      bus(1'b0, a, 32'h0);
      chk(q, e);
   endtask : rc
   // k selects tx push, tx pop, rx push, rx pop; counts settle before return
   task automatic fifo(input int k, n);
      fop <= 4'h1 << k;
      repeat (n) @(posedge hclk);
      fop <= 4'h0;
      repeat (3) @(posedge hclk);
   endtask : fifo
   task automatic pulse(input int k);
      ev <= ev | (11'h1 << k);
      @(posedge hclk);
      ev <= ev & ~(11'h1 << k);
      repeat (2) @(posedge hclk);
   endtask : pulse
   task automatic tend();
      tn++;
      $display("test %0d done", tn);
   endtask : tend
   function automatic logic [31:0] txe(input int n, l);
      return {29'h0, n == 0, n < DEPTH, n < l};
   endfunction : txe
   function automatic logic [31:0] rxe(input int n, l);
      return {29'h0, n == DEPTH, n != 0, n > l};
   endfunction : rxe
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_of_test
   ////////////////////////////////
   // a few hundred cycles of traffic; a hang ends here
   initial begin
      #40000;
      failures++;
      end_of_test();
   end
   initial begin
      void'($urandom(84609));
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rc(OFS_TX_REQ, txe(0, 0));
      rc(32'h100, 32'h0);
      bus(1'b1, OFS_TX_LEVEL, 32'hF);
      rc(OFS_TX_LEVEL, DEPTH - 1);
      r = 4'($urandom % DEPTH);
      bus(1'b1, OFS_TX_LEVEL, 32'h3);
      bus(1'b1, OFS_RX_LEVEL, r);
      bus(1'b1, OFS_TX_REQ, 32'hFF);
      rc(OFS_TX_REQ, txe(0, 3));
      rc(OFS_RX_LEVEL, r);
      chk(tx_lvl, 32'h3);
      chk(rx_lvl, r);
      tend();
      fifo(2, DEPTH + 1);
      rc(OFS_RX_REQ, rxe(DEPTH, r) | (1 << RXB_OVF));
      bus(1'b1, OFS_RX_REQ, 32'h7F);
      rc(OFS_RX_REQ, rxe(DEPTH, r));
      fifo(3, DEPTH + 1);
      rc(OFS_RX_REQ, rxe(DEPTH, r) | (1 << RXB_UNF));
      bus(1'b1, OFS_RX_REQ, 32'h7F);
      tend();
      fifo(0, DEPTH + 1);
      rc(OFS_TX_REQ, txe(0, 3) | (1 << TXB_OVF));
      bus(1'b1, OFS_TX_REQ, 32'hFF);
      rc(OFS_TX_REQ, 32'h0);
      ev.tgt_stretch <= 1'b1;
      fifo(1, DEPTH + 1);
      bus(1'b1, OFS_TX_REQ, 32'hFF);
      rc(OFS_TX_REQ, txe(0, 3) | (1 << TXB_UNF));
      pulse(0);
      bus(1'b1, OFS_TX_REQ, 32'hFF);
      rc(OFS_TX_REQ, txe(0, 3));
      ev.tgt_stretch <= 1'b0;
      tend();
      // each single-cycle fault lands on its own request bit only
      foreach (ek[i]) begin
         pulse(ek[i]);
         rc(OFS_TX_REQ, txe(0, 3) | (i < 3 ? 1 << (TXB_NACK + i) : 0));
         rc(OFS_RX_REQ, i < 3 ? 0 : 1 << (RXB_STOP + i - 3));
         bus(1'b1, OFS_TX_REQ, 32'hFF);
         bus(1'b1, OFS_RX_REQ, 32'hFF);
      end
      tend();
      // forced bits, masks, masked view, cause and irq; first pass sets nothing
      for (int i = 0; i < 4; i++) begin
         s = (i == 0) ? 32'h0 : $urandom % 256;
         m = $urandom;
         ctl_req <= 16'($urandom);
         tgt_req <= 16'($urandom);
         bus(1'b1, OFS_TX_SET, s);
         bus(1'b1, OFS_RX_SET, s >> 1);
         bus(1'b1, OFS_TX_MASK, m);
         bus(1'b1, OFS_RX_MASK, m >> 8);
         bus(1'b1, OFS_CTL_MASK, m);
         bus(1'b1, OFS_TGT_MASK, ~m);
         rc(OFS_TX_REQ, s | txe(0, 3));
         rc(OFS_TX_MASK, m[7:0]);
         rc(OFS_TX_MASKED, (s | txe(0, 3)) & m[7:0]);
         // rx fifo is empty here, so only forced bits show in the rx group
         x = (s >> 1) & (m >> 8) & 32'h7F;
         rc(OFS_RX_REQ, (s >> 1) & 32'h7F);
         rc(OFS_RX_MASK, (m >> 8) & 32'h7F);
         rc(OFS_RX_MASKED, x);
         c = {28'h0, |x, |((s | txe(0, 3)) & m[7:0]), |(tgt_req & ~m[15:0]),
              |(ctl_req & m[15:0])};
         rc(OFS_CAUSE, c);
         chk(irq, |c);
         bus(1'b1, OFS_TX_REQ, 32'hFF);
         bus(1'b1, OFS_RX_REQ, 32'hFF);
      end
      tend();
      // mid-run reset brings masks, levels and irq back to zero
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk(irq, 32'h0);
      rc(OFS_TX_MASK, 32'h0);
      rc(OFS_TX_REQ, txe(0, 0));
      chk(tx_lvl, 32'h0);
      tend();
      end_of_test();
   end
endmodule : fim_top_tb
